// ### pllcr_pkg.sv
// constants and decode helpers for the loop control register bank
`default_nettype none
package pllcr_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int NREG = 7;
  localparam int REF_W = 14;
  localparam int SWALLOW_W = 6;
  localparam int MAIN_W = 13;
  localparam int FB_W = 19;
  localparam int PSC_W = 6;
  localparam logic [ADDR_W-1:0] ADDR_LOOP = 10'h010;
  localparam logic [ADDR_W-1:0] ADDR_REF_LO = 10'h011;
  localparam logic [ADDR_W-1:0] ADDR_REF_HI = 10'h012;
  localparam logic [ADDR_W-1:0] ADDR_SWALLOW = 10'h013;
  localparam logic [ADDR_W-1:0] ADDR_MAIN_LO = 10'h014;
  localparam logic [ADDR_W-1:0] ADDR_MAIN_HI = 10'h015;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 10'h016;
  localparam logic [2:0] IDX_LOOP = 3'h0;
  localparam logic [2:0] IDX_REF_LO = 3'h1;
  localparam logic [2:0] IDX_REF_HI = 3'h2;
  localparam logic [2:0] IDX_SWALLOW = 3'h3;
  localparam logic [2:0] IDX_MAIN_LO = 3'h4;
  localparam logic [2:0] IDX_MAIN_HI = 3'h5;
  localparam logic [2:0] IDX_CTRL = 3'h6;
  // reset values, index order loop .. ctrl
  localparam logic [NREG-1:0][DATA_W-1:0] RST_VAL = {8'h06, 8'h00, 8'h03, 8'h00, 8'h00, 8'h01, 8'h7d};
  // writable bits; reserved bits stay zero and read as zero
  localparam logic [NREG-1:0][DATA_W-1:0] WR_MASK = {8'hff, 8'h1f, 8'hff, 8'h3f, 8'h3f, 8'hff, 8'hff};
  // loop register fields
  localparam int POL_BIT = 7;
  localparam int CPI_HI = 6;
  localparam int CPI_LO = 4;
  localparam int CPM_HI = 3;
  localparam int CPM_LO = 2;
  localparam int PD_HI = 1;
  localparam int PD_LO = 0;
  // counter control register fields
  localparam int HALF_BIT = 7;
  localparam int RST_REF_BIT = 6;
  localparam int RST_FB_BIT = 5;
  localparam int RST_ALL_BIT = 4;
  localparam int BYPASS_BIT = 3;
  localparam int PSC_HI = 2;
  localparam int PSC_LO = 0;
  localparam int REF_HI_BITS = 6;
  localparam int MAIN_HI_BITS = 5;
  localparam logic [MAIN_W-1:0] MAIN_ONE = 13'h0001;

  typedef enum logic [1:0] {
    PLLCR_CP_HIGHZ = 2'h0,
    PLLCR_CP_SOURCE = 2'h1,
    PLLCR_CP_SINK = 2'h2,
    PLLCR_CP_NORMAL = 2'h3
  } pllcr_cp_mode_type;

  typedef enum logic [2:0] {
    PLLCR_PSC_FD1 = 3'h0,
    PLLCR_PSC_FD2 = 3'h1,
    PLLCR_PSC_DM2 = 3'h2,
    PLLCR_PSC_DM4 = 3'h3,
    PLLCR_PSC_DM8 = 3'h4,
    PLLCR_PSC_DM16 = 3'h5,
    PLLCR_PSC_DM32 = 3'h6,
    PLLCR_PSC_FD3 = 3'h7
  } pllcr_psc_type;

  // base modulus of the prescaler
  function automatic logic [PSC_W-1:0] psc_modulus(input logic [2:0] code);
    unique case (pllcr_psc_type'(code))
      PLLCR_PSC_FD1: psc_modulus = 6'h01;
      PLLCR_PSC_FD2: psc_modulus = 6'h02;
      PLLCR_PSC_DM2: psc_modulus = 6'h02;
      PLLCR_PSC_DM4: psc_modulus = 6'h04;
      PLLCR_PSC_DM8: psc_modulus = 6'h08;
      PLLCR_PSC_DM16: psc_modulus = 6'h10;
      PLLCR_PSC_DM32: psc_modulus = 6'h20;
      PLLCR_PSC_FD3: psc_modulus = 6'h03;
    endcase
  endfunction : psc_modulus

  function automatic logic psc_dual(input logic [2:0] code);
    psc_dual = (code >= 3'(PLLCR_PSC_DM2)) && (code <= 3'(PLLCR_PSC_DM32));
  endfunction : psc_dual

  // maps a bus address onto a bank index
  function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] off;
    off = addr - ADDR_LOOP;
    reg_index = off[2:0];
  endfunction : reg_index

  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr);
    reg_hit = (addr >= ADDR_LOOP) && (addr <= ADDR_CTRL);
  endfunction : reg_hit
endpackage : pllcr_pkg
`default_nettype wire

// ### pllcr_divider.sv
// programmable counter: one output pulse per divisor input ticks
`timescale 1ns/10ps
`default_nettype none
module pllcr_divider #(
  parameter int WIDTH = 14
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic tick,
  input wire logic hold,
  input wire logic [WIDTH-1:0] divisor,
  output logic pulse_r
);
  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;
  logic pulse_nxt;

  always_comb begin
    count_nxt = count_r;
    pulse_nxt = 1'b0;
    if (hold) begin
      // restart from the initial state once released
      count_nxt = '0;
    end else if (tick) begin
      // a divisor of zero behaves as one
      if ((count_r + WIDTH'(1)) >= divisor) begin
        count_nxt = '0;
        pulse_nxt = 1'b1;
      end else begin
        count_nxt = count_r + WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      count_r <= '0;
      pulse_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  hold_quiet_a: assert property (@(posedge clock) disable iff (!arst_n) hold |=> !pulse_r)
    else $error("divider pulsed while held");
  pulse_cause_a: assert property (@(posedge clock) disable iff (!arst_n) pulse_r |-> $past(tick) && !$past(hold))
    else $error("divider pulsed without a tick");
endmodule : pllcr_divider
`default_nettype wire

// ### pllcr_regs.sv
// loop control register bank with buffer and active copies, and the loop dividers
`timescale 1ns/10ps
`default_nettype none
module pllcr_regs (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic soft_reset,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [pllcr_pkg::ADDR_W-1:0] addr,
  input wire logic [pllcr_pkg::DATA_W-1:0] wr_data,
  input wire logic update_regs,
  input wire logic readback_active,
  input wire logic ref_tick,
  input wire logic fb_tick,
  output logic [pllcr_pkg::DATA_W-1:0] rd_data_r,
  output logic pfd_negative,
  output logic [2:0] cp_current,
  output logic [1:0] cp_mode,
  output logic [1:0] loop_pd_mode,
  output logic cp_half_supply,
  output logic [pllcr_pkg::REF_W-1:0] ref_div,
  output logic [pllcr_pkg::SWALLOW_W-1:0] swallow_count,
  output logic [pllcr_pkg::MAIN_W-1:0] main_count,
  output logic main_bypass,
  output logic [2:0] prescaler_code,
  output logic ref_hold_r,
  output logic fb_hold_r,
  output logic ref_out_r,
  output logic fb_out_r
);
  logic [pllcr_pkg::NREG-1:0][pllcr_pkg::DATA_W-1:0] buf_r;
  logic [pllcr_pkg::NREG-1:0][pllcr_pkg::DATA_W-1:0] buf_nxt;
  logic [pllcr_pkg::NREG-1:0][pllcr_pkg::DATA_W-1:0] act_r;
  logic [pllcr_pkg::NREG-1:0][pllcr_pkg::DATA_W-1:0] act_nxt;
  logic [pllcr_pkg::DATA_W-1:0] rd_data_nxt;
  logic ref_hold_nxt;
  logic fb_hold_nxt;
  logic [pllcr_pkg::FB_W-1:0] fb_div_r;
  logic [pllcr_pkg::FB_W-1:0] fb_div_nxt;
  logic [pllcr_pkg::REF_W-1:0] ref_div_r;
  logic [pllcr_pkg::DATA_W-1:0] ctrl_act;
  logic [pllcr_pkg::MAIN_W-1:0] main_eff;
  logic [pllcr_pkg::PSC_W-1:0] modulus;
  logic [2:0] wr_idx;

  assign ctrl_act = act_r[pllcr_pkg::IDX_CTRL];
  assign wr_idx = pllcr_pkg::reg_index(addr);

  // bank: writes go to the buffer copy, an update moves it to the active copy
  always_comb begin
    buf_nxt = buf_r;
    act_nxt = act_r;
    if (soft_reset) begin
      // soft reset is level sensitive; it wins over a write in the same cycle
      buf_nxt = pllcr_pkg::RST_VAL;
      act_nxt = pllcr_pkg::RST_VAL;
    end else begin
      if (update_regs) begin
        act_nxt = buf_r;
      end
      if (wr_en && pllcr_pkg::reg_hit(addr)) begin
        buf_nxt[wr_idx] = wr_data & pllcr_pkg::WR_MASK[wr_idx];
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      buf_r <= pllcr_pkg::RST_VAL;
      act_r <= pllcr_pkg::RST_VAL;
    end else begin
      buf_r <= buf_nxt;
      act_r <= act_nxt;
    end
  end

  // readback: one cycle latency, unmapped addresses return zero
  always_comb begin
    rd_data_nxt = rd_data_r;
    if (rd_en) begin
      if (!pllcr_pkg::reg_hit(addr)) begin
        rd_data_nxt = '0;
      end else if (readback_active) begin
        rd_data_nxt = act_r[wr_idx];
      end else begin
        rd_data_nxt = buf_r[wr_idx];
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_r <= '0;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  // field outputs are plain wiring from active flops
  assign pfd_negative = act_r[pllcr_pkg::IDX_LOOP][pllcr_pkg::POL_BIT];
  assign cp_current = act_r[pllcr_pkg::IDX_LOOP][pllcr_pkg::CPI_HI:pllcr_pkg::CPI_LO];
  assign cp_mode = act_r[pllcr_pkg::IDX_LOOP][pllcr_pkg::CPM_HI:pllcr_pkg::CPM_LO];
  assign loop_pd_mode = act_r[pllcr_pkg::IDX_LOOP][pllcr_pkg::PD_HI:pllcr_pkg::PD_LO];
  assign cp_half_supply = ctrl_act[pllcr_pkg::HALF_BIT];
  assign ref_div = {act_r[pllcr_pkg::IDX_REF_HI][pllcr_pkg::REF_HI_BITS-1:0], act_r[pllcr_pkg::IDX_REF_LO]};
  assign swallow_count = act_r[pllcr_pkg::IDX_SWALLOW][pllcr_pkg::SWALLOW_W-1:0];
  assign main_count = {act_r[pllcr_pkg::IDX_MAIN_HI][pllcr_pkg::MAIN_HI_BITS-1:0], act_r[pllcr_pkg::IDX_MAIN_LO]};
  assign main_bypass = ctrl_act[pllcr_pkg::BYPASS_BIT];
  assign prescaler_code = ctrl_act[pllcr_pkg::PSC_HI:pllcr_pkg::PSC_LO];

  // feedback ratio; bypass in a dual-modulus mode is not guarded, software must avoid it
  always_comb begin
    main_eff = main_bypass ? pllcr_pkg::MAIN_ONE : main_count;
    modulus = pllcr_pkg::psc_modulus(prescaler_code);
    fb_div_nxt = pllcr_pkg::FB_W'(modulus) * pllcr_pkg::FB_W'(main_eff);
    if (pllcr_pkg::psc_dual(prescaler_code)) begin
      fb_div_nxt = fb_div_nxt + pllcr_pkg::FB_W'(swallow_count);
    end
    ref_hold_nxt = ctrl_act[pllcr_pkg::RST_REF_BIT] | ctrl_act[pllcr_pkg::RST_ALL_BIT];
    fb_hold_nxt = ctrl_act[pllcr_pkg::RST_FB_BIT] | ctrl_act[pllcr_pkg::RST_ALL_BIT];
  end

  // registered so a ratio change settles before the counters see it
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fb_div_r <= '0;
      ref_div_r <= '0;
      ref_hold_r <= 1'b1;
      fb_hold_r <= 1'b1;
    end else begin
      fb_div_r <= fb_div_nxt;
      ref_div_r <= ref_div;
      ref_hold_r <= ref_hold_nxt;
      fb_hold_r <= fb_hold_nxt;
    end
  end

  pllcr_divider #(.WIDTH(pllcr_pkg::REF_W)) u_ref_div (
    .clock(clock),
    .arst_n(arst_n),
    .tick(ref_tick),
    .hold(ref_hold_r),
    .divisor(ref_div_r),
    .pulse_r(ref_out_r)
  );

  pllcr_divider #(.WIDTH(pllcr_pkg::FB_W)) u_fb_div (
    .clock(clock),
    .arst_n(arst_n),
    .tick(fb_tick),
    .hold(fb_hold_r),
    .divisor(fb_div_r),
    .pulse_r(fb_out_r)
  );

  sequence write_to(logic [pllcr_pkg::ADDR_W-1:0] a);
    wr_en && !soft_reset && addr == a;
  endsequence

  sequence read_buffer(logic [pllcr_pkg::ADDR_W-1:0] a);
    rd_en && !readback_active && addr == a && !wr_en && !soft_reset;
  endsequence

  pol_field_a: assert property (@(posedge clock) disable iff (!arst_n)
    (update_regs && !soft_reset) |=> pfd_negative == $past(buf_r[pllcr_pkg::IDX_LOOP][pllcr_pkg::POL_BIT]))
    else $error("polarity output does not follow the loop register");
  // write, one idle cycle, then a buffer read of the same register
  write_read_a: assert property (@(posedge clock) disable iff (!arst_n)
    write_to(pllcr_pkg::ADDR_LOOP) ##1 (!wr_en && !soft_reset) ##1 read_buffer(pllcr_pkg::ADDR_LOOP)
    |=> rd_data_r == $past(wr_data, 3))
    else $error("buffer readback lost the written value");
  active_wait_a: assert property (@(posedge clock) disable iff (!arst_n)
    (!update_regs && !soft_reset) |=> act_r == $past(act_r))
    else $error("active copy changed without an update");
  update_copy_a: assert property (@(posedge clock) disable iff (!arst_n)
    (update_regs && !soft_reset) |=> act_r == $past(buf_r))
    else $error("update did not move buffer to active");
  soft_defaults_a: assert property (@(posedge clock) disable iff (!arst_n)
    soft_reset |=> cp_mode == 2'h3 && loop_pd_mode == 2'h1 && ref_div == 14'h0001 && main_count == 13'h0003)
    else $error("soft reset did not restore defaults");
  swallow_mask_a: assert property (@(posedge clock) disable iff (!arst_n)
    buf_r[pllcr_pkg::IDX_SWALLOW][7:6] == 2'h0 && buf_r[pllcr_pkg::IDX_MAIN_HI][7:5] == 3'h0)
    else $error("reserved bits were stored");
  all_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
    ctrl_act[4] |=> ref_hold_r && fb_hold_r ##1 !ref_out_r && !fb_out_r)
    else $error("reset-all did not hold every counter");
  fb_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
    ctrl_act[5] |=> fb_hold_r)
    else $error("feedback counters not held");
  ref_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
    ctrl_act[pllcr_pkg::RST_REF_BIT] |=> ref_hold_r)
    else $error("reference counter not held");
  hold_release_a: assert property (@(posedge clock) disable iff (!arst_n)
    (!ctrl_act[pllcr_pkg::RST_ALL_BIT] && !ctrl_act[pllcr_pkg::RST_REF_BIT]
      && !ctrl_act[pllcr_pkg::RST_FB_BIT]) |=> !ref_hold_r && !fb_hold_r)
    else $error("counters held with every reset bit clear");
  bypass_ratio_a: assert property (@(posedge clock) disable iff (!arst_n)
    (main_bypass && !pllcr_pkg::psc_dual(prescaler_code)) |=> fb_div_r == 19'($past(modulus)))
    else $error("bypass did not reduce feedback to the prescaler");
  dual_ratio_a: assert property (@(posedge clock) disable iff (!arst_n)
    (prescaler_code == 3'h2 && !main_bypass) |=> fb_div_r == 19'(2 * $past(main_count) + $past(swallow_count)))
    else $error("dual modulus ratio is wrong");
  unmapped_zero_a: assert property (@(posedge clock) disable iff (!arst_n)
    (rd_en && addr == 10'h017) |=> rd_data_r == 8'h00)
    else $error("unmapped read returned data");
endmodule : pllcr_regs
`default_nettype wire

// ### pllcr_host.sv
// host software model driving the register bus of the loop control bank
`timescale 1ns/10ps
`default_nettype none
module pllcr_host (
  input wire logic clock,
  output logic soft_reset,
  output logic wr_en,
  output logic rd_en,
  output logic [pllcr_pkg::ADDR_W-1:0] addr,
  output logic [pllcr_pkg::DATA_W-1:0] wr_data,
  output logic update_regs,
  output logic readback_active,
  input wire logic [pllcr_pkg::DATA_W-1:0] rd_data_r
);
  initial begin
    {soft_reset, wr_en, rd_en, update_regs, readback_active} = 5'h00;
    addr = 10'h000;
    wr_data = 8'h00;
  end
  // every task waits an edge first, so a strobe never falls and rises in one time step
  // callers keep polarity zero except with an external oscillator, bypass only in fixed divide
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    wr_en = 1'b1;
    addr = a;
    wr_data = d;
    @(posedge clock);
    #1;
    wr_en = 1'b0;
  endtask : wr
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge clock);
    #1;
    rd_en = 1'b1;
    addr = a;
    @(posedge clock);
    #1;
    rd_en = 1'b0;
    d = rd_data_r;
  endtask : rd
  // copy buffer to active; holds land one cycle after the fields
  task automatic upd();
    @(posedge clock);
    #1;
    update_regs = 1'b1;
    @(posedge clock);
    #1;
    update_regs = 1'b0;
    repeat (2) @(posedge clock);
    #1;
  endtask : upd
  task automatic sr();
    @(posedge clock);
    #1;
    soft_reset = 1'b1;
    @(posedge clock);
    #1;
    soft_reset = 1'b0;
  endtask : sr
  task automatic sel(input logic b);
    @(posedge clock);
    #1;
    readback_active = b;
  endtask : sel
endmodule : pllcr_host
`default_nettype wire

// ### pll_control_registers_bench.sv
// self-checking bench for the loop control register bank
`timescale 1ns/10ps
`default_nettype none
module pll_control_registers_bench;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic ref_tick = 1'b0;
  logic fb_tick = 1'b0;
  logic soft_reset, wr_en, rd_en, update_regs, readback_active;
  logic [9:0] addr;
  logic [7:0] wr_data, rd_data_r;
  logic pfd_negative, cp_half_supply, main_bypass, ref_hold_r, fb_hold_r, ref_out_r, fb_out_r;
  logic [2:0] cp_current, prescaler_code;
  logic [1:0] cp_mode, loop_pd_mode;
  logic [13:0] ref_div;
  logic [5:0] swallow_count;
  logic [12:0] main_count;
  int miscompares = 0;
  int tests_run = 0;

  always #10 clock = ~clock;

  pllcr_host i_host (.clock(clock), .soft_reset(soft_reset), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wr_data(wr_data), .update_regs(update_regs), .readback_active(readback_active), .rd_data_r(rd_data_r));

  pllcr_regs i_dut (.clock(clock), .arst_n(arst_n), .soft_reset(soft_reset), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wr_data(wr_data), .update_regs(update_regs), .readback_active(readback_active),
    .ref_tick(ref_tick), .fb_tick(fb_tick), .rd_data_r(rd_data_r), .pfd_negative(pfd_negative),
    .cp_current(cp_current), .cp_mode(cp_mode), .loop_pd_mode(loop_pd_mode), .cp_half_supply(cp_half_supply),
    .ref_div(ref_div), .swallow_count(swallow_count), .main_count(main_count), .main_bypass(main_bypass),
    .prescaler_code(prescaler_code), .ref_hold_r(ref_hold_r), .fb_hold_r(fb_hold_r), .ref_out_r(ref_out_r),
    .fb_out_r(fb_out_r));

  // wide enough for the 33-bit divider concatenations
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [9:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_host.rd(a, d);
    chk(d, exp);
  endtask : rdchk

  // one tick per cycle on both inputs, then a few idle cycles to catch the last pulse
  task automatic ticks(input int n, output int rc, output int fc);
    rc = 0;
    fc = 0;
    for (int i = 0; i < n + 3; i++) begin
      ref_tick = (i < n);
      fb_tick = (i < n);
      @(posedge clock);
      #1;
      rc += int'(ref_out_r === 1'b1);
      fc += int'(fb_out_r === 1'b1);
    end
  endtask : ticks

  task automatic t_reset();
    logic [7:0] dflt [7] = '{8'h7d, 8'h01, 8'h00, 8'h00, 8'h03, 8'h00, 8'h06};
    chk({rd_data_r, ref_out_r, fb_out_r}, 10'h000);
    for (int i = 0; i < 7; i++) begin
      rdchk(10'h010 + 10'(i), dflt[i]);
    end
    chk({pfd_negative, cp_mode, loop_pd_mode}, 5'h0d);
    chk({ref_div, main_count, swallow_count}, {14'h0001, 13'h0003, 6'h00});
    chk({cp_half_supply, ref_hold_r, fb_hold_r, main_bypass}, 4'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_bank();
    i_host.wr(10'h012, 8'hff);
    i_host.wr(10'h013, 8'hff);
    i_host.wr(10'h015, 8'hff);
    i_host.wr(10'h017, 8'h5a);
    rdchk(10'h012, 8'h3f);
    rdchk(10'h013, 8'h3f);
    rdchk(10'h015, 8'h1f);
    rdchk(10'h017, 8'h00);
    i_host.sel(1'b1);
    rdchk(10'h012, 8'h00);
    i_host.upd();
    rdchk(10'h012, 8'h3f);
    chk({ref_div, main_count, swallow_count}, {14'h3f01, 13'h1f03, 6'h3f});
    i_host.sr();
    rdchk(10'h012, 8'h00);
    i_host.sel(1'b0);
    chk({ref_div, main_count}, {14'h0001, 13'h0003});
    $display("test bank done");
  endtask : t_bank

  task automatic t_loop();
    logic [2:0] cur;
    for (int m = 0; m < 4; m++) begin
      cur = (m == 3) ? 3'h6 : 3'(m + 2);
      // polarity one only as an external oscillator would allow
      i_host.wr(10'h010, {m[0], cur, 2'(m), 2'(3 - m)});
      rdchk(10'h010, {m[0], cur, 2'(m), 2'(3 - m)});
      i_host.upd();
      chk({pfd_negative, cp_current, cp_mode, loop_pd_mode}, {m[0], cur, 2'(m), 2'(3 - m)});
    end
    $display("test loop fields done");
  endtask : t_loop

  // ref divide 3, feedback 2/3 prescaler with main 2 and swallow 1, so 5
  task automatic t_holds();
    logic [7:0] ctl [4] = '{8'h02, 8'h42, 8'h12, 8'h22};
    logic [1:0] hx [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
    int rc, fc;
    i_host.wr(10'h011, 8'h03);
    i_host.wr(10'h014, 8'h02);
    i_host.wr(10'h013, 8'h01);
    for (int i = 0; i < 4; i++) begin
      i_host.wr(10'h016, ctl[i]);
      i_host.upd();
      chk({ref_hold_r, fb_hold_r}, hx[i]);
      ticks(15, rc, fc);
      chk(rc, hx[i][1] ? 0 : 5);
      chk(fc, hx[i][0] ? 0 : 3);
    end
    $display("test holds done");
  endtask : t_holds

  task automatic t_modes();
    int pm [8] = '{1, 2, 2, 4, 8, 16, 32, 3};
    int rc, fc, nf;
    for (int c = 0; c < 8; c++) begin
      nf = pm[c] * 2 + ((c >= 2 && c <= 6) ? 1 : 0);
      i_host.wr(10'h016, 8'(c));
      i_host.upd();
      chk(prescaler_code, c);
      ticks(2 * nf, rc, fc);
      chk(fc, 2);
    end
    i_host.wr(10'h016, 8'h89);
    i_host.upd();
    chk({cp_half_supply, main_bypass}, 2'h3);
    ticks(14, rc, fc);
    chk(fc, 7);
    $display("test modes done");
  endtask : t_modes

  task automatic print_verdict();
    $display("counts: tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (10) @(posedge clock);
    #1;
    arst_n = 1'b1;
    t_reset();
    t_bank();
    t_loop();
    t_holds();
    t_modes();
    print_verdict();
  end

  // cuts a hang short
  initial begin
    #1000000;
    miscompares++;
    print_verdict();
  end
endmodule : pll_control_registers_bench
`default_nettype wire
